// ---- logic/lane_ctl_pkg.sv ----
/*
 lane_ctl_pkg: register map, reset values and field layout for the lane power and marker input control.
 assumes a 32-bit AXI4-Lite register bus and one 250 MHz clock.
*/
`default_nettype none
package lane_ctl_pkg;
	localparam int          LANES        = 8;
	localparam int          MODE_W       = 8;
	localparam int          FMT_W        = 5;
	localparam int          CNT_W        = 16;
	localparam int          FMT0_LANES   = 4;
	localparam logic [11:0] CTRL_ADDR    = 12'h000;
	localparam logic [11:0] MODE_ADDR    = 12'h004;
	localparam logic [11:0] FMT_ADDR     = 12'h008;
	localparam logic [11:0] STATUS_ADDR  = 12'h00C;
	localparam logic [11:0] MARKCNT_ADDR = 12'h010;
	localparam logic [7:0]  MODE_NORM0   = 8'h00;
	localparam logic [7:0]  MODE_NORM1   = 8'h01;
	localparam logic [7:0]  MODE_RST     = 8'h00;
	localparam logic [4:0]  FMT_RST      = 5'h00;
	localparam logic [1:0]  RESP_OKAY    = 2'b00;
	localparam logic [1:0]  RESP_SLVERR  = 2'b10;

	// control register, bit 7 downward
	typedef struct packed {
		logic keep_b;
		logic keep_a;
		logic ch_b_off;
		logic ch_a_off;
		logic dc_term_en;
		logic rx_en;
		logic sync_sel;
		logic mark_en;
	} ctrl_t;

	localparam ctrl_t CTRL_RST = '0;

	// merge one write byte under its strobe
	function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [7:0] wd, input logic strb);
		merge_byte = strb ? wd : old;
	endfunction

	// lanes of one link used by a link format
	function automatic logic [LANES-1:0] used_lanes(input logic [FMT_W-1:0] fmt);
		logic [LANES-1:0] m;
		m = '1;
		if (fmt == FMT_RST) begin
			m = '0;
			m[FMT0_LANES-1:0] = '1;
		end
		used_lanes = m;
	endfunction
endpackage
`default_nettype wire

// ---- logic/lane_power_and_marker_input_ctl.sv ----
/*
 lane_power_and_marker_input_ctl: marker input use, link sync source and serializer lane power.
 assumes pins synchronous to clk, an AXI4-Lite master keeping one write and one read at most in flight.
*/
// Behaviour
// RQ1: mark enable tags sample on marker assertion
// RQ2: sync select takes sync from marker pair
// RQ3: marker may serve as mark and sync
// RQ4: sync request on marker pair is active low
// RQ5: software enables marker receiver before use
// RQ6: power-down pin turns off all lanes
// RQ7: non-normal operating mode turns off all lanes
// RQ8: channel power-off kills channel and its lanes
// RQ9: format-unused lanes are powered down
// RQ10: keep-alive keeps unused lanes powered and toggling
// RQ11: power-down pin and modes only briefly
// RQ12: sync select 0 uses single-ended low sync
// RQ13: lane on only if no source turns off
`timescale 1ns/1ns
`default_nettype none
module lane_power_and_marker_input_ctl
	import lane_ctl_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic             marker_input_pos,
	input  wire logic             marker_input_neg,
	input  wire logic             single_ended_sync_pin_n,
	input  wire logic             power_down_pin,
	output logic                  sample_mark_r,
	output logic                  link_sync_req_n_r,
	output logic                  marker_dc_termination_enable_r,
	output logic                  chan_a_on_r,
	output logic                  chan_b_on_r,
	output logic [LANES-1:0]      lane_on_a_r,
	output logic [LANES-1:0]      lane_on_b_r,
	output logic [LANES-1:0]      lane_fill_a_r,
	output logic [LANES-1:0]      lane_fill_b_r,
	input  wire logic [11:0]      s_axi_awaddr,
	input  wire logic             s_axi_awvalid,
	output logic                  s_axi_awready,
	input  wire logic [31:0]      s_axi_wdata,
	input  wire logic [3:0]       s_axi_wstrb,
	input  wire logic             s_axi_wvalid,
	output logic                  s_axi_wready,
	output logic [1:0]            s_axi_bresp,
	output logic                  s_axi_bvalid,
	input  wire logic             s_axi_bready,
	input  wire logic [11:0]      s_axi_araddr,
	input  wire logic             s_axi_arvalid,
	output logic                  s_axi_arready,
	output logic [31:0]           s_axi_rdata,
	output logic [1:0]            s_axi_rresp,
	output logic                  s_axi_rvalid,
	input  wire logic             s_axi_rready
);
	ctrl_t              ctrl_r;
	logic [MODE_W-1:0]  mode_r;
	logic [FMT_W-1:0]   fmt_r;
	logic [CNT_W-1:0]   mark_cnt_r;
	logic [11:0]        waddr_r;
	logic [31:0]        wdata_r;
	logic [3:0]         wstrb_r;
	logic               aw_got_r;
	logic               w_got_r;
	logic               marker_q_r;
	logic               aw_hs;
	logic               w_hs;
	logic               do_write;
	logic [11:0]        wa;
	logic [31:0]        wd;
	logic [3:0]         ws;
	logic               marker_hi;
	logic               marker_lo;
	logic               all_off;
	logic [LANES-1:0]   used;
	logic [31:0]        rd_nxt;

	// write path: address and data taken in either order, applied once both are in
	assign aw_hs    = s_axi_awvalid & s_axi_awready;
	assign w_hs     = s_axi_wvalid & s_axi_wready;
	assign do_write = (aw_got_r | aw_hs) & (w_got_r | w_hs);
	assign wa       = aw_got_r ? waddr_r : s_axi_awaddr;
	assign wd       = w_got_r ? wdata_r : s_axi_wdata;
	assign ws       = w_got_r ? wstrb_r : s_axi_wstrb;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_awready <= 1'b1;
			aw_got_r      <= 1'b0;
			waddr_r       <= '0;
		end else begin
			if (aw_hs) begin
				s_axi_awready <= 1'b0;
				waddr_r       <= s_axi_awaddr;
			end else if (s_axi_bvalid & s_axi_bready) begin
				s_axi_awready <= 1'b1;
			end
			aw_got_r <= do_write ? 1'b0 : (aw_got_r | aw_hs);
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_wready <= 1'b1;
			w_got_r      <= 1'b0;
			wdata_r      <= '0;
			wstrb_r      <= '0;
		end else begin
			if (w_hs) begin
				s_axi_wready <= 1'b0;
				wdata_r      <= s_axi_wdata;
				wstrb_r      <= s_axi_wstrb;
			end else if (s_axi_bvalid & s_axi_bready) begin
				s_axi_wready <= 1'b1;
			end
			w_got_r <= do_write ? 1'b0 : (w_got_r | w_hs);
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (wa == CTRL_ADDR || wa == MODE_ADDR || wa == FMT_ADDR) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// only the low byte of control and mode, and the low five bits of format, are writable; status and mark count are read-only
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_r <= CTRL_RST;
			mode_r <= MODE_RST;
			fmt_r  <= FMT_RST;
		end else if (do_write) begin
			if (wa == CTRL_ADDR)
				ctrl_r <= ctrl_t'(merge_byte(ctrl_r, wd[7:0], ws[0]));
			if (wa == MODE_ADDR)
				mode_r <= merge_byte(mode_r, wd[7:0], ws[0]);
			if (wa == FMT_ADDR)
				fmt_r <= FMT_W'(merge_byte({3'h0, fmt_r}, wd[7:0], ws[0]));
		end
	end

	// read path
	always_comb begin
		rd_nxt = '0;
		unique case (s_axi_araddr)
			CTRL_ADDR:    rd_nxt[7:0] = ctrl_r;
			MODE_ADDR:    rd_nxt[7:0] = mode_r;
			FMT_ADDR:     rd_nxt[FMT_W-1:0] = fmt_r;
			STATUS_ADDR:  rd_nxt[17:0] = {all_off, link_sync_req_n_r, lane_on_b_r, lane_on_a_r};
			MARKCNT_ADDR: rd_nxt[CNT_W-1:0] = mark_cnt_r;
			default:      rd_nxt = '0;
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_arvalid & s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_nxt;
			s_axi_rresp   <= (s_axi_araddr <= MARKCNT_ADDR && s_axi_araddr[1:0] == 2'b00) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid & s_axi_rready) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
		end
	end

	// marker pair is dead unless software enabled its receiver first
	assign marker_hi = ctrl_r.rx_en & marker_input_pos & ~marker_input_neg; // see RQ5
	assign marker_lo = ctrl_r.rx_en & ~marker_input_pos & marker_input_neg;

	// marking runs whatever the sync source, so one pair can do both jobs
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			marker_q_r    <= 1'b0;
			sample_mark_r <= 1'b0;
			mark_cnt_r    <= '0;
		end else begin
			marker_q_r    <= marker_hi;
			sample_mark_r <= ctrl_r.mark_en & marker_hi & ~marker_q_r; // see RQ1 see RQ3
			if (ctrl_r.mark_en & marker_hi & ~marker_q_r)
				mark_cnt_r <= mark_cnt_r + 1'b1;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			link_sync_req_n_r              <= 1'b1;
			marker_dc_termination_enable_r <= 1'b0;
		end else begin
			if (ctrl_r.sync_sel)
				link_sync_req_n_r <= ~marker_lo; // see RQ2 see RQ4
			else
				link_sync_req_n_r <= single_ended_sync_pin_n; // see RQ12
			marker_dc_termination_enable_r <= ctrl_r.dc_term_en;
		end
	end

	// lane power: any off source wins; keep-alive only rescues format-unused lanes
	assign all_off = power_down_pin | (mode_r != MODE_NORM0 && mode_r != MODE_NORM1); // see RQ6 see RQ7
	assign used    = used_lanes(fmt_r); // see RQ9

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			lane_on_a_r   <= '0;
			lane_on_b_r   <= '0;
			lane_fill_a_r <= '0;
			lane_fill_b_r <= '0;
			chan_a_on_r   <= 1'b0;
			chan_b_on_r   <= 1'b0;
		end else begin
			lane_on_a_r   <= (all_off | ctrl_r.ch_a_off) ? '0 : (used | {LANES{ctrl_r.keep_a}}); // see RQ8 see RQ10 see RQ13
			lane_on_b_r   <= (all_off | ctrl_r.ch_b_off) ? '0 : (used | {LANES{ctrl_r.keep_b}}); // see RQ8 see RQ10 see RQ13
			lane_fill_a_r <= (all_off | ctrl_r.ch_a_off | ~ctrl_r.keep_a) ? '0 : ~used; // see RQ10
			lane_fill_b_r <= (all_off | ctrl_r.ch_b_off | ~ctrl_r.keep_b) ? '0 : ~used; // see RQ10
			chan_a_on_r   <= ~ctrl_r.ch_a_off; // see RQ8
			chan_b_on_r   <= ~ctrl_r.ch_b_off; // see RQ8
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_pin_all_off: assert property ($past(power_down_pin) |-> lane_on_a_r == '0 && lane_on_b_r == '0) // see RQ6
		else $error("lanes on while power-down pin high");
	a_mode_all_off: assert property ($past(mode_r) > MODE_NORM1 |-> lane_on_a_r == '0 && lane_on_b_r == '0) // see RQ7
		else $error("lanes on in non-normal mode");
	a_chan_a_off: assert property ($past(ctrl_r.ch_a_off) |-> lane_on_a_r == '0 && !chan_a_on_r) // see RQ8
		else $error("channel a lanes on while powered off");
	a_fmt_unused: assert property ($past(fmt_r) == FMT_RST && !$past(ctrl_r.keep_b) |-> lane_on_b_r[LANES-1:FMT0_LANES] == '0) // see RQ9
		else $error("unused lanes powered");
	a_keep_alive: assert property ($past(ctrl_r.keep_a) && !$past(all_off) && !$past(ctrl_r.ch_a_off)
		|-> &lane_on_a_r && lane_fill_a_r == ~$past(used)) // see RQ10
		else $error("keep-alive lanes not on");
	a_mark_pulse: assert property (sample_mark_r |-> $past(ctrl_r.mark_en) ##1 !sample_mark_r) // see RQ1
		else $error("mark pulse without enable or too long");
	a_sync_diff: assert property ($past(ctrl_r.sync_sel) |-> link_sync_req_n_r == !$past(marker_lo)) // see RQ2 see RQ4
		else $error("differential sync request wrong");
	a_sync_se: assert property (!$past(ctrl_r.sync_sel) |-> link_sync_req_n_r == $past(single_ended_sync_pin_n)) // see RQ12
		else $error("single-ended sync request wrong");
	a_rx_off: assert property (!$past(ctrl_r.rx_en) |-> !sample_mark_r) // see RQ5
		else $error("mark with receiver disabled");
	a_both_uses: assert property ($past(ctrl_r.sync_sel & ctrl_r.mark_en & marker_hi & ~marker_q_r)
		|-> sample_mark_r && link_sync_req_n_r) // see RQ3
		else $error("marker and sync roles clash");
	a_lane_combine: assert property (|lane_on_b_r |-> !$past(power_down_pin) && !$past(ctrl_r.ch_b_off)) // see RQ13
		else $error("lane on against an off source");
	a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");

	c_mark: cover property (sample_mark_r);
	c_diff_sync: cover property (ctrl_r.sync_sel && !link_sync_req_n_r);
	c_keep: cover property (|lane_fill_a_r);
	c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule
`default_nettype wire

// ---- verification/far_end_link_model.sv ----
/*
 far_end_link_model: far-end link receiver driving the marker pair as its sync request.
 assumes the bench commands want_sync after a clock edge.
*/
`timescale 1ns/1ns
`default_nettype none
module far_end_link_model (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic want_sync,
	output logic      pair_pos,
	output logic      pair_neg
);
	// low level asks for resync; its release is a rising marker edge, so the sync feeds back as a mark
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pair_pos <= 1'h1;
			pair_neg <= 1'h0;
		end else begin
			pair_pos <= ~want_sync;
			pair_neg <= want_sync;
		end
	end
endmodule
`default_nettype wire

// ---- verification/lane_power_and_marker_input_ctl_bench.sv ----
/*
 lane_power_and_marker_input_ctl_bench: self-checking bench for lane power and marker input use.
 assumes the package and the far-end link model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module lane_power_and_marker_input_ctl_bench import lane_ctl_pkg::*;;
	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] mode;
		logic [4:0] fmt;
		logic       pin_off;
		logic [31:0] lanes;
	} row_t;
	logic        clk, sys_rst, marker_input_pos, marker_input_neg, single_ended_sync_pin_n, power_down_pin;
	logic        sample_mark_r, link_sync_req_n_r, marker_dc_termination_enable_r, chan_a_on_r, chan_b_on_r;
	logic [7:0]  lane_on_a_r, lane_on_b_r, lane_fill_a_r, lane_fill_b_r;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd, n;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, want_sync;
	int          failures, total_checks, cycles;
	row_t        rows [12];

	lane_power_and_marker_input_ctl i_dut (.clk, .sys_rst, .marker_input_pos, .marker_input_neg,
		.single_ended_sync_pin_n, .power_down_pin, .sample_mark_r, .link_sync_req_n_r,
		.marker_dc_termination_enable_r, .chan_a_on_r, .chan_b_on_r, .lane_on_a_r, .lane_on_b_r,
		.lane_fill_a_r, .lane_fill_b_r, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready);
	far_end_link_model i_far (.clk, .sys_rst, .want_sync, .pair_pos(marker_input_pos),
		.pair_neg(marker_input_neg));

	initial begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic print_verdict;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	// hang guard, far above the few hundred cycles the sequence needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			$display("ERROR %0t: timeout", $time);
			print_verdict;
		end
	end

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic aw, w;
		aw = 1'h0;
		w = 1'h0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (!(aw && w)) begin
			@(posedge clk);
			if (s_axi_awready && s_axi_awvalid) begin
				aw = 1'h1;
				s_axi_awvalid <= 1'h0;
			end
			if (s_axi_wready && s_axi_wvalid) begin
				w = 1'h1;
				s_axi_wvalid <= 1'h0;
			end
		end
		do @(posedge clk); while (!s_axi_bvalid);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask

	task automatic rdr(input logic [11:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(posedge clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		do @(posedge clk); while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask

	initial begin
		{sys_rst, single_ended_sync_pin_n} = 2'h3;
		{power_down_pin, want_sync, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		{failures, total_checks, cycles} = '0;
		// ctrl, mode, format, pin, then lanes a, lanes b, filler a, filler b
		rows[0] = {8'h00, 8'h00, 5'h00, 1'h0, 32'h0F0F_0000};
		rows[1] = {8'h00, 8'h01, 5'h00, 1'h0, 32'h0F0F_0000};
		rows[2] = {8'h00, 8'h02, 5'h00, 1'h0, 32'h0000_0000};
		rows[3] = {8'h00, 8'hFF, 5'h00, 1'h0, 32'h0000_0000};
		rows[4] = {8'h00, 8'h00, 5'h01, 1'h0, 32'hFFFF_0000};
		rows[5] = {8'hC0, 8'h00, 5'h00, 1'h0, 32'hFFFF_F0F0};
		rows[6] = {8'h40, 8'h00, 5'h00, 1'h0, 32'hFF0F_F000};
		rows[7] = {8'h10, 8'h00, 5'h00, 1'h0, 32'h000F_0000};
		rows[8] = {8'h20, 8'h00, 5'h00, 1'h0, 32'h0F00_0000};
		rows[9] = {8'hD0, 8'h00, 5'h00, 1'h0, 32'h00FF_00F0};
		rows[10] = {8'hC0, 8'h00, 5'h00, 1'h1, 32'h0000_0000};
		rows[11] = {8'hC0, 8'h03, 5'h00, 1'h0, 32'h0000_0000};
		repeat (10) @(posedge clk);
		chk({link_sync_req_n_r, chan_a_on_r, lane_on_a_r, lane_on_b_r}, {1'h1, 17'h0});
		sys_rst <= 1'h0;
		repeat (2) @(posedge clk);
		chk({chan_a_on_r, chan_b_on_r, lane_on_a_r, lane_on_b_r}, {2'h3, 16'h0F0F});
		wr(12'h020, 32'h0000_00FF);
		chk(rsp, RESP_SLVERR);
		rdr(12'h020);
		chk({rsp, rd}, {RESP_SLVERR, 32'h0});
		// pin and off modes held a few cycles per row, except the last row's mode 03, kept until the mid-run reset
		foreach (rows[i]) begin
			wr(CTRL_ADDR, {24'h0, rows[i].ctrl});
			wr(MODE_ADDR, {24'h0, rows[i].mode});
			wr(FMT_ADDR, {27'h0, rows[i].fmt});
			power_down_pin <= rows[i].pin_off;
			repeat (3) @(posedge clk);
			chk({lane_on_a_r, lane_on_b_r, lane_fill_a_r, lane_fill_b_r}, rows[i].lanes);
			chk({chan_a_on_r, chan_b_on_r}, {~rows[i].ctrl[4], ~rows[i].ctrl[5]});
			rdr(STATUS_ADDR);
			chk({rsp, rd[15:0]}, {RESP_OKAY, rows[i].lanes[23:16], rows[i].lanes[31:24]});
		end
		power_down_pin <= 1'h0;
		wr(CTRL_ADDR, 32'h0000_0003);
		want_sync <= 1'h1;
		repeat (4) @(posedge clk);
		chk(link_sync_req_n_r, 1'h1);
		wr(CTRL_ADDR, 32'h0000_0007);
		repeat (4) @(posedge clk);
		chk(link_sync_req_n_r, 1'h0);
		want_sync <= 1'h0;
		n = '0;
		repeat (6) begin
			@(posedge clk);
			#1 n = n + sample_mark_r;
		end
		chk({n, link_sync_req_n_r}, {32'h1, 1'h1});
		rdr(MARKCNT_ADDR);
		chk(rd, 32'h1);
		wr(CTRL_ADDR, 32'h0000_000D);
		single_ended_sync_pin_n <= 1'h0;
		repeat (3) @(posedge clk);
		chk({link_sync_req_n_r, marker_dc_termination_enable_r}, 2'h1);
		single_ended_sync_pin_n <= 1'h1;
		repeat (3) @(posedge clk);
		chk(link_sync_req_n_r, 1'h1);
		// mid-run reset must bring back format 0 lanes and clear the mark count
		sys_rst <= 1'h1;
		@(posedge clk);
		sys_rst <= 1'h0;
		repeat (2) @(posedge clk);
		chk({chan_a_on_r, chan_b_on_r, lane_on_a_r, lane_on_b_r}, {2'h3, 16'h0F0F});
		rdr(MARKCNT_ADDR);
		chk({rsp, rd}, {RESP_OKAY, 32'h0});
		print_verdict;
	end
endmodule
`default_nettype wire
